/* rtl/utcia_top.sv */
// usb transceiver control and indirect core register access port
// Notes on behaviour
// [R1] eight endpoint pipes: control endpoint zero both ways, endpoints one-three IN and OUT
// [R2] control pipes at protocol address 0x00; IN pipes 0x80+n, OUT pipes n
// [R3] speed bit one: full speed, pull-up placed on D+
// [R4] speed bit zero: low speed, pull-up placed on D-
// [R5] pull-up connects only while enable bit set and VBUS present
// [R6] phy enable bit one turns transceiver on; zero disables and suspends it
// [R7] test field: 00 normal, 01 D+ high, 10 D- high, 11 both low
// [R8] differential receiver bit shows bus differential value while phy enabled
// [R9] bits one and zero show live D+ and D- pin levels
// [R10] indirect address picks the core register for every data access
// [R11] six-bit indirect address, never changed by hardware during auto reads
// [R12] endpoint registers route to endpoint last written into the index register
// [R13] writing busy one starts an indirect read; zero has no effect
// [R14] busy clears once fetched data sits in data register
// [R15] software polls busy for zero before data writes or new accesses
// [R16] auto-read set: each data register read starts the next indirect read; the code starts none for a data read made while busy is set
// [R17] usb clock must run during indirect accesses
// [R18] usb clock should run before phy is enabled
// [R19] data writes go to the selected core register; reads return last fetch
// [R20] endpoint select accepts zero to three; four to fifteen are reserved
// [R21] indirect read finishes in a fixed short time; busy spans it
`timescale 1ns/100ps
module utcia_top (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // special-function register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // usb function core register port
    output logic core_wr_out,
    output logic core_rd_out,
    output logic [5:0] indirect_reg_addr_out,
    output logic [7:0] core_wdata_out,
    input wire logic [7:0] core_rdata_in,
    output logic [3:0] endpoint_select_out,
    output logic endpoint_reserved_out,
    // usb bus pins and sense
    input wire logic vbus_present_in,
    input wire logic dplus_in,
    input wire logic dminus_in,
    output logic dplus_out,
    output logic dplus_oe_out,
    output logic dminus_out,
    output logic dminus_oe_out,
    output logic pullup_dplus_out,
    output logic pullup_dminus_out,
    output logic phy_enable_out,
    output logic phy_suspend_out,
    output logic full_speed_out,
    // endpoint protocol address table, eight pipes
    output logic [63:0] pipe_protocol_addr_out
);
    // =====================================================
    // register state
    // =====================================================
    logic [7:0] indirect_address_q;
    logic [7:0] xcvr_ctrl_q;
    logic [7:0] indirect_data_q;
    logic [3:0] endpoint_select_q;
    logic reserved_q;
    logic [2:0] read_count_q;
    logic busy_q;
    logic [7:0] sfr_rdata_q;
    logic core_wr_q;
    logic [7:0] core_wdata_q;
    logic [7:0] core_capture_q;

    // bus pins are asynchronous to the clock
    logic [2:0] pins_sync;
    logic vbus_sync;
    logic dplus_sync;
    logic dminus_sync;

    utcia_sync2 #(
        .WIDTH(3)
    ) u_pin_sync (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .async_in({vbus_present_in, dplus_in, dminus_in}),
        .sync_out(pins_sync)
    );

    assign vbus_sync = pins_sync[2];
    assign dplus_sync = pins_sync[1];
    assign dminus_sync = pins_sync[0];

    // =====================================================
    // access decode
    // =====================================================
    logic wr_addr_reg;
    logic wr_data_reg;
    logic wr_xcvr_reg;
    logic rd_data_reg;
    logic start_read;
    logic [5:0] target_addr;
    logic auto_read;

    assign wr_addr_reg = sfr_wr_in && (sfr_addr_in == utcia_pkg::ADDR_INDIRECT_ADDRESS);
    assign wr_data_reg = sfr_wr_in && (sfr_addr_in == utcia_pkg::ADDR_INDIRECT_DATA);
    assign wr_xcvr_reg = sfr_wr_in && (sfr_addr_in == utcia_pkg::ADDR_TRANSCEIVER_CONTROL);
    assign rd_data_reg = sfr_rd_in && (sfr_addr_in == utcia_pkg::ADDR_INDIRECT_DATA);
    assign target_addr = indirect_address_q[utcia_pkg::ADDR_FIELD_MSB:0];
    assign auto_read = indirect_address_q[utcia_pkg::BIT_AUTO_READ];

    // manual start by writing busy one; auto start on a data read
    assign start_read = (wr_addr_reg && sfr_wdata_in[utcia_pkg::BIT_BUSY]) // [R13]
        || (rd_data_reg && auto_read && !busy_q); // [R16]

    // =====================================================
    // indirect address register
    // =====================================================
    // address bits only move on software writes, never on auto reads
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            indirect_address_q <= utcia_pkg::RESET_INDIRECT_ADDRESS;
        end else if (wr_addr_reg) begin
            indirect_address_q <= {1'b0, sfr_wdata_in[utcia_pkg::BIT_AUTO_READ],
                sfr_wdata_in[utcia_pkg::ADDR_FIELD_MSB:0]}; // [R10] [R11]
        end
    end

    // =====================================================
    // busy flag and read sequencer
    // =====================================================
    // a fresh start while busy restarts the count, so data is never stale
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_q <= 1'b0;
            read_count_q <= 3'h0;
        end else if (start_read) begin
            busy_q <= 1'b1; // [R13] [R21]
            read_count_q <= utcia_pkg::READ_CYCLES;
        end else if (busy_q) begin
            read_count_q <= read_count_q - 3'h1;
            if (read_count_q == 3'h1) begin
                busy_q <= 1'b0; // [R14] [R21]
            end
        end
    end

    // core strobe held for the whole read so the core samples a stable address
    assign core_rd_out = busy_q;

    // capture core data one cycle before busy drops
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            core_capture_q <= utcia_pkg::RESET_INDIRECT_DATA;
        end else if (busy_q && read_count_q == 3'h2) begin
            core_capture_q <= core_rdata_in;
        end
    end

    // =====================================================
    // indirect data register
    // =====================================================
    // loaded exactly as busy clears, so busy low always means valid data
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            indirect_data_q <= utcia_pkg::RESET_INDIRECT_DATA;
        end else if (busy_q && read_count_q == 3'h1) begin
            indirect_data_q <= (utcia_pkg::READ_CYCLES == 3'h1) ? core_rdata_in : core_capture_q; // [R14] [R19]
        end
    end

    // write-through to the core; software must wait for busy low first
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            core_wr_q <= 1'b0;
            core_wdata_q <= 8'h00;
        end else begin
            core_wr_q <= wr_data_reg && !busy_q; // [R19] [R15]
            if (wr_data_reg && !busy_q) begin
                core_wdata_q <= sfr_wdata_in;
            end
        end
    end

    assign core_wr_out = core_wr_q;
    assign core_wdata_out = core_wdata_q;
    assign indirect_reg_addr_out = target_addr; // [R10]

    // =====================================================
    // endpoint index shadow
    // =====================================================
    // tracks writes to the core index register to steer indexed accesses
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            endpoint_select_q <= utcia_pkg::RESET_ENDPOINT_SELECT;
            reserved_q <= 1'b0;
        end else if (wr_data_reg && !busy_q && target_addr == utcia_pkg::CORE_INDEX_ADDR) begin
            endpoint_select_q <= sfr_wdata_in[3:0]; // [R12]
            reserved_q <= (sfr_wdata_in[3:0] > utcia_pkg::MAX_ENDPOINT); // [R20]
        end
    end

    assign endpoint_select_out = endpoint_select_q;
    // reserved selects are flagged; the core ignores indexed access then
    assign endpoint_reserved_out = reserved_q;

    // =====================================================
    // transceiver control register
    // =====================================================
    // usb clock presence is the system's duty, not checked here
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            xcvr_ctrl_q <= utcia_pkg::RESET_TRANSCEIVER_CONTROL;
        end else begin
            if (wr_xcvr_reg) begin
                xcvr_ctrl_q[7:3] <= sfr_wdata_in[7:3]; // [R18]
            end
            // live status fields are read-only
            xcvr_ctrl_q[utcia_pkg::BIT_DIFF_RECEIVER] <= xcvr_ctrl_q[utcia_pkg::BIT_PHY_ENABLE]
                ? (dplus_sync & ~dminus_sync) : 1'b0; // [R8]
            xcvr_ctrl_q[utcia_pkg::BIT_DPLUS_LEVEL] <= dplus_sync; // [R9]
            xcvr_ctrl_q[utcia_pkg::BIT_DMINUS_LEVEL] <= dminus_sync; // [R9]
        end
    end

    logic pullup_en;
    logic phy_en;
    logic speed_full;
    utcia_pkg::utcia_test_type test_mode;

    assign pullup_en = xcvr_ctrl_q[utcia_pkg::BIT_PULLUP_ENABLE];
    assign phy_en = xcvr_ctrl_q[utcia_pkg::BIT_PHY_ENABLE];
    assign speed_full = xcvr_ctrl_q[utcia_pkg::BIT_SPEED];
    assign test_mode = utcia_pkg::utcia_test_type'(
        xcvr_ctrl_q[utcia_pkg::TEST_FIELD_MSB:utcia_pkg::TEST_FIELD_LSB]);

    // =====================================================
    // pin drive
    // =====================================================
    logic pu_dp_q;
    logic pu_dm_q;
    logic phy_q;
    logic dp_q;
    logic dm_q;
    logic oe_q;
    logic susp_q;
    logic fs_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pu_dp_q <= 1'b0;
            pu_dm_q <= 1'b0;
            fs_q <= 1'b0;
        end else begin
            pu_dp_q <= pullup_en && vbus_sync && speed_full; // [R3] [R5]
            pu_dm_q <= pullup_en && vbus_sync && !speed_full; // [R4] [R5]
            fs_q <= speed_full && ((pullup_en && vbus_sync) || phy_en); // [R3]
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phy_q <= 1'b0;
            susp_q <= 1'b1;
        end else begin
            phy_q <= phy_en; // [R6]
            susp_q <= !phy_en; // [R6]
        end
    end

    // forced line states, only while the transceiver is on
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dp_q <= 1'b0;
            dm_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            unique case (test_mode) // [R7]
                utcia_pkg::UTCIA_TEST_NORMAL: begin
                    dp_q <= 1'b0;
                    dm_q <= 1'b0;
                    oe_q <= 1'b0;
                end
                utcia_pkg::UTCIA_TEST_DIFF_ONE: begin
                    dp_q <= 1'b1;
                    dm_q <= 1'b0;
                    oe_q <= phy_en;
                end
                utcia_pkg::UTCIA_TEST_DIFF_ZERO: begin
                    dp_q <= 1'b0;
                    dm_q <= 1'b1;
                    oe_q <= phy_en;
                end
                utcia_pkg::UTCIA_TEST_SE0: begin
                    dp_q <= 1'b0;
                    dm_q <= 1'b0;
                    oe_q <= phy_en;
                end
            endcase
        end
    end

    assign pullup_dplus_out = pu_dp_q;
    assign pullup_dminus_out = pu_dm_q;
    assign phy_enable_out = phy_q;
    assign phy_suspend_out = susp_q;
    assign full_speed_out = fs_q;
    assign dplus_out = dp_q;
    assign dminus_out = dm_q;
    assign dplus_oe_out = oe_q;
    assign dminus_oe_out = oe_q;

    // =====================================================
    // endpoint pipe protocol addresses
    // =====================================================
    // pipe 2n is OUT, 2n+1 is IN of endpoint n
    logic [15:0] pipe_addr_q [utcia_pkg::NUM_ENDPOINTS];
    genvar ep;
    generate
        for (ep = 0; ep < utcia_pkg::NUM_ENDPOINTS; ep++) begin : g_pipe
            always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    pipe_addr_q[ep] <= 16'h0000;
                end else if (ep == 0) begin
                    pipe_addr_q[ep] <= {utcia_pkg::EP_CONTROL_ADDR, utcia_pkg::EP_CONTROL_ADDR}; // [R1] [R2]
                end else begin
                    pipe_addr_q[ep] <= {utcia_pkg::EP_IN_DIR_BIT | 8'(ep), 8'(ep)}; // [R1] [R2]
                end
            end
        end
    endgenerate

    assign pipe_protocol_addr_out = {pipe_addr_q[3], pipe_addr_q[2], pipe_addr_q[1], pipe_addr_q[0]};

    // =====================================================
    // register read back
    // =====================================================
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_rd_in) begin
            unique case (sfr_addr_in)
                utcia_pkg::ADDR_INDIRECT_ADDRESS: sfr_rdata_q <= {busy_q, indirect_address_q[6:0]}; // [R14]
                utcia_pkg::ADDR_INDIRECT_DATA: sfr_rdata_q <= indirect_data_q; // [R19]
                utcia_pkg::ADDR_TRANSCEIVER_CONTROL: sfr_rdata_q <= xcvr_ctrl_q;
                default: sfr_rdata_q <= 8'h00;
            endcase
        end
    end

    assign sfr_rdata_out = sfr_rdata_q;
endmodule : utcia_top

/* rtl/utcia_pkg.sv */
// package: special-function register map, field positions and timing for the usb transceiver control block
package utcia_pkg;
    // special-function register addresses
    localparam logic [7:0] ADDR_INDIRECT_ADDRESS = 8'h96;
    localparam logic [7:0] ADDR_INDIRECT_DATA = 8'h97;
    localparam logic [7:0] ADDR_TRANSCEIVER_CONTROL = 8'hd7;
    // reset values
    localparam logic [7:0] RESET_INDIRECT_ADDRESS = 8'h00;
    localparam logic [7:0] RESET_TRANSCEIVER_CONTROL = 8'h00;
    localparam logic [7:0] RESET_INDIRECT_DATA = 8'h00;
    localparam logic [3:0] RESET_ENDPOINT_SELECT = 4'h0;
    // indirect address register fields
    localparam int BIT_BUSY = 7;
    localparam int BIT_AUTO_READ = 6;
    localparam int ADDR_FIELD_MSB = 5;
    localparam int ADDR_WIDTH = 6;
    // transceiver control register fields
    localparam int BIT_PULLUP_ENABLE = 7;
    localparam int BIT_PHY_ENABLE = 6;
    localparam int BIT_SPEED = 5;
    localparam int TEST_FIELD_MSB = 4;
    localparam int TEST_FIELD_LSB = 3;
    localparam int BIT_DIFF_RECEIVER = 2;
    localparam int BIT_DPLUS_LEVEL = 1;
    localparam int BIT_DMINUS_LEVEL = 0;
    // core register addresses the indirect port knows about
    localparam logic [5:0] CORE_INDEX_ADDR = 6'h0e;
    localparam logic [3:0] MAX_ENDPOINT = 4'h3;
    localparam int NUM_ENDPOINTS = 4;
    // endpoint protocol addresses
    localparam logic [7:0] EP_IN_DIR_BIT = 8'h80;
    localparam logic [7:0] EP_CONTROL_ADDR = 8'h00;
    // indirect read latency
    localparam int READ_TIME_NS = 40;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [2:0] READ_CYCLES = 3'((READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // physical test modes
    typedef enum logic [1:0] {
        UTCIA_TEST_NORMAL = 2'h0,
        UTCIA_TEST_DIFF_ONE = 2'h1,
        UTCIA_TEST_DIFF_ZERO = 2'h2,
        UTCIA_TEST_SE0 = 2'h3
    } utcia_test_type;
endpackage : utcia_pkg

/* rtl/utcia_sync2.sv */
// two-stage synchroniser for pin levels
`timescale 1ns/100ps
module utcia_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // asynchronous level in, synchronised level out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : utcia_sync2

/* verif/utcia_top_sva.sv */
// checker: port-level assertions for the transceiver control and indirect access block
`timescale 1ns/100ps
module utcia_top_sva (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    // core port
    input wire logic core_wr_out,
    input wire logic core_rd_out,
    input wire logic [5:0] indirect_reg_addr_out,
    input wire logic [7:0] core_wdata_out,
    input wire logic [3:0] endpoint_select_out,
    input wire logic endpoint_reserved_out,
    // pins
    input wire logic vbus_present_in,
    input wire logic dplus_out,
    input wire logic dminus_out,
    input wire logic dplus_oe_out,
    input wire logic phy_enable_out,
    input wire logic pullup_dplus_out,
    input wire logic pullup_dminus_out,
    input wire logic [63:0] pipe_protocol_addr_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic adr_wr;
    logic dat_wr;
    logic [5:0] wlow;
    assign adr_wr = sfr_wr_in && sfr_addr_in == utcia_pkg::ADDR_INDIRECT_ADDRESS;
    assign dat_wr = sfr_wr_in && sfr_addr_in == utcia_pkg::ADDR_INDIRECT_DATA;
    assign wlow = sfr_wdata_in[5:0];
    // ==========================================
    // indirect access
    AST_BUSY_SPAN: assert property (adr_wr && sfr_wdata_in[7] && !core_rd_out |=>
        core_rd_out [*4] ##1 !core_rd_out) else $error("busy span wrong");
    AST_ZERO_IDLE: assert property (adr_wr && !sfr_wdata_in[7] && !core_rd_out |=> !core_rd_out)
        else $error("busy write zero started a read");
    AST_ADDR_LOAD: assert property (adr_wr && !core_rd_out |=> indirect_reg_addr_out == $past(wlow))
        else $error("indirect address not loaded");
    AST_ADDR_HOLD: assert property (!adr_wr |=> $stable(indirect_reg_addr_out))
        else $error("indirect address moved by itself");
    AST_DATA_WR: assert property (dat_wr && !core_rd_out |=> core_wr_out && core_wdata_out == $past(sfr_wdata_in))
        else $error("data write not passed to core");
    AST_WR_CAUSE: assert property (core_wr_out |-> $past(dat_wr))
        else $error("core write without data write");
    AST_DROP: assert property (dat_wr && core_rd_out |=> !core_wr_out)
        else $error("data write during busy passed on");
    AST_RDATA_HOLD: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
        else $error("read data changed without read");
    // ==========================================
    // transceiver and endpoints
    AST_PULLUP_VBUS: assert property (!vbus_present_in [*5] |-> !pullup_dplus_out && !pullup_dminus_out)
        else $error("pull-up without vbus");
    AST_PULLUP_ONE: assert property (!(pullup_dplus_out && pullup_dminus_out))
        else $error("pull-up on both lines");
    AST_FORCE_OE: assert property (dplus_oe_out |-> phy_enable_out && !(dplus_out && dminus_out))
        else $error("forced line state illegal");
    AST_INDEX_RES: assert property (endpoint_reserved_out == (endpoint_select_out > 4'h3))
        else $error("reserved endpoint flag wrong");
    AST_PIPE_TABLE: assert property ($past(rst_n_in) |-> pipe_protocol_addr_out == 64'h8303_8202_8101_0000)
        else $error("pipe address table wrong");
    cover property (adr_wr && sfr_wdata_in[7]);
    cover property (dat_wr && core_rd_out);
    cover property (core_wr_out);
    cover property (endpoint_reserved_out);
endmodule : utcia_top_sva

bind utcia_top utcia_top_sva utcia_top_sva_inst (.ref_clk_in, .rst_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in,
    .sfr_wdata_in, .sfr_rdata_out, .core_wr_out, .core_rd_out, .indirect_reg_addr_out, .core_wdata_out,
    .endpoint_select_out, .endpoint_reserved_out, .vbus_present_in, .dplus_out, .dminus_out, .dplus_oe_out,
    .phy_enable_out, .pullup_dplus_out, .pullup_dminus_out, .pipe_protocol_addr_out);

/* verif/utcia_core_model.sv */
// partner model: usb function core register file behind the indirect port
`timescale 1ns/100ps
module utcia_core_model (
    // clock, shared so the core clock always runs during access
    input wire logic ref_clk_in,
    // core register port
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [5:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    logic [7:0] mem_q [64];
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem_q[i] = 8'(i * 37 + 90);
        end
    end
    // data outside a read is inverted so a mistimed capture shows up
    assign rdata_out = rd_in ? mem_q[addr_in] : ~mem_q[addr_in];
    always @(posedge ref_clk_in) begin
        if (wr_in) begin
            mem_q[addr_in] <= wdata_in;
        end
    end
endmodule : utcia_core_model

/* verif/tb_utcia_top.sv */
// testbench: transceiver control and indirect register access
`timescale 1ns/100ps
module tb_utcia_top;
    localparam logic [7:0] A_ADR = utcia_pkg::ADDR_INDIRECT_ADDRESS;
    localparam logic [7:0] A_DAT = utcia_pkg::ADDR_INDIRECT_DATA;
    localparam logic [7:0] A_XCN = utcia_pkg::ADDR_TRANSCEIVER_CONTROL;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic sfr_wr_in = 1'b0;
    logic sfr_rd_in = 1'b0;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic vbus_present_in = 1'b0;
    logic dplus_in = 1'b0;
    logic dminus_in = 1'b0;
    logic [7:0] sfr_rdata_out, core_wdata_out, core_rdata_in, v, d;
    logic core_wr_out, core_rd_out, endpoint_reserved_out, dplus_out, dplus_oe_out, dminus_out, dminus_oe_out;
    logic pullup_dplus_out, pullup_dminus_out, phy_enable_out, phy_suspend_out, full_speed_out;
    logic [5:0] indirect_reg_addr_out, a;
    logic [3:0] endpoint_select_out;
    logic [63:0] pipe_protocol_addr_out;
    logic [7:0] exp_mem [64];
    int n_errors = 0;
    int check_count = 0;
    int seed = 32'h4663;

    utcia_top utcia_top_inst (.ref_clk_in, .rst_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in,
        .sfr_rdata_out, .core_wr_out, .core_rd_out, .indirect_reg_addr_out, .core_wdata_out, .core_rdata_in,
        .endpoint_select_out, .endpoint_reserved_out, .vbus_present_in, .dplus_in, .dminus_in, .dplus_out,
        .dplus_oe_out, .dminus_out, .dminus_oe_out, .pullup_dplus_out, .pullup_dminus_out, .phy_enable_out,
        .phy_suspend_out, .full_speed_out, .pipe_protocol_addr_out);
    utcia_core_model utcia_core_model_inst (.ref_clk_in, .wr_in(core_wr_out), .rd_in(core_rd_out),
        .addr_in(indirect_reg_addr_out), .wdata_in(core_wdata_out), .rdata_out(core_rdata_in));

    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    // ==========================================
    // expectations and bus tasks
    function automatic logic [7:0] exp_pins(input logic [7:0] x, input logic vb);
        logic att;
        logic [1:0] lv;
        att = x[7] & vb;
        lv = (x[4:3] == 2'h1) ? 2'b10 : (x[4:3] == 2'h2) ? 2'b01 : 2'b00;
        if (!x[6] || x[4:3] == 2'h0) begin
            lv = 2'b00;
        end
        return {att & x[5], att & !x[5], x[6], !x[6], x[5] & (att | x[6]), lv, x[6] && x[4:3] != 2'h0};
    endfunction : exp_pins
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge ref_clk_in);
        sfr_wr_in <= 1'b1;
        sfr_addr_in <= ad;
        sfr_wdata_in <= dt;
        @(posedge ref_clk_in);
        sfr_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
        @(posedge ref_clk_in);
        sfr_rd_in <= 1'b1;
        sfr_addr_in <= ad;
        @(posedge ref_clk_in);
        sfr_rd_in <= 1'b0;
        #1;
        dt = sfr_rdata_out;
    endtask : rd
    // bounded poll of the busy flag
    task automatic wait_idle();
        for (int i = 0; i < 20; i++) begin
            rd(A_ADR, v);
            if (v[7] === 1'b0) begin
                return;
            end
        end
        n_errors++;
        end_sim();
    endtask : wait_idle
    task automatic fetch(input logic [5:0] ad, input logic [1:0] mode);
        wr(A_ADR, {mode, ad});
        rd(A_ADR, v);
        chk(v, {mode, ad}, "busy after start");
        wait_idle();
        rd(A_DAT, d);
        chk(d, exp_mem[ad], "indirect read");
    endtask : fetch
    // ==========================================
    // main sequence
    initial begin
        for (int i = 0; i < 64; i++) begin
            exp_mem[i] = 8'(i * 37 + 90);
        end
        repeat (5) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rd(A_ADR, d);
        chk(d, utcia_pkg::RESET_INDIRECT_ADDRESS, "address reset");
        rd(A_XCN, d);
        chk(d, utcia_pkg::RESET_TRANSCEIVER_CONTROL, "control reset");
        vbus_present_in <= 1'b1;
        for (int m = 0; m < 32; m++) begin
            v = 8'(m << 3);
            wr(A_XCN, v | 8'h07);
            repeat (2) @(posedge ref_clk_in);
            rd(A_XCN, d);
            chk(d, v, "control readback");
            chk({pullup_dplus_out, pullup_dminus_out, phy_enable_out, phy_suspend_out, full_speed_out,
                dplus_out & dplus_oe_out, dminus_out & dminus_oe_out, dplus_oe_out & dminus_oe_out},
                exp_pins(v, 1'b1), "line control");
        end
        vbus_present_in <= 1'b0;
        wr(A_XCN, 8'he0);
        rd(A_XCN, d);
        repeat (3) @(posedge ref_clk_in);
        rd(A_XCN, d);
        chk({pullup_dplus_out, pullup_dminus_out, 6'h00}, 8'h00, "detached without vbus");
        for (int m = 0; m < 8; m++) begin
            v = {1'b0, m[2], 6'h00};
            wr(A_XCN, v);
            dplus_in <= m[1];
            dminus_in <= m[0];
            repeat (4) @(posedge ref_clk_in);
            rd(A_XCN, d);
            chk(d, {v[7:3], m[2] & m[1] & !m[0], m[1], m[0]}, "pin status");
        end
        fetch(6'h00, 2'b10);
        fetch(6'h3f, 2'b10);
        repeat (6) begin
            a = 6'($random(seed));
            fetch(a, 2'b10);
            a = 6'($random(seed));
            d = 8'($random(seed));
            wr(A_ADR, {2'b00, a});
            rd(A_ADR, v);
            chk(v, {2'b00, a}, "busy zero write");
            wr(A_DAT, d);
            exp_mem[a] = d;
            fetch(a, 2'b10);
            wr(A_ADR, {2'b10, a});
            wr(A_DAT, ~d);
            wait_idle();
            fetch(a, 2'b10);
        end
        a = 6'($random(seed));
        fetch(a, 2'b11);
        for (int i = 0; i < 3; i++) begin
            rd(A_ADR, v);
            chk(v, {2'b11, a}, "auto read restart");
            wait_idle();
            rd(A_DAT, d);
            chk(d, exp_mem[a], "auto read data");
        end
        wait_idle();
        fetch(a, 2'b10);
        rd(A_ADR, v);
        chk(v, {2'b00, a}, "manual read no restart");
        wr(A_ADR, {2'b00, utcia_pkg::CORE_INDEX_ADDR});
        for (int e = 0; e < 16; e += 5) begin
            wr(A_DAT, 8'(e));
            rd(8'h55, d);
            chk(d, 8'h00, "unmapped read");
            chk({endpoint_reserved_out, 3'h0, endpoint_select_out}, {e > 3, 3'h0, 4'(e)}, "endpoint index");
        end
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rd(A_ADR, d);
        chk(d, 8'h00, "address after second reset");
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        n_errors++;
        end_sim();
    end
endmodule : tb_utcia_top
